// >>> design/expbus_sup_pkg.sv
/*
  Package for the expansion bus error supervisor: register offsets, field
  positions, status codes, timing counts, state enum and the carrier structs.
  Assumes a single 100 MHz clock domain and a fixed chain of eight modules.
*/
package expbus_sup_pkg;

  localparam int N_MOD = 8;
  localparam int DATA_W = 8;
  localparam int HOLD_W = 30;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_SYSFAULT = 8'h08;
  localparam logic [7:0] OFS_IOSTAT = 8'h0c;
  localparam logic [7:0] OFS_QUERY = 8'h10;
  localparam logic [7:0] OFS_BUSSTAT = 8'h14;
  localparam logic [7:0] OFS_MODSTATE = 8'h20;
  localparam logic [7:0] OFS_OUTIMG = 8'h40;
  localparam logic [7:0] OFS_INIMG = 8'h60;
  localparam logic [7:0] OFS_END = 8'h80;
  localparam logic [7:0] OFS_BANK_MASK = 8'he0;

  // Control register bits
  localparam int CTRL_PASSIVE_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_RESETCMD_BIT = 2;

  // Configuration register fields
  localparam int CFG_PRESENT_LSB = 0;
  localparam int CFG_OPTIONAL_LSB = 8;
  localparam int CFG_NEWER_LSB = 16;
  localparam logic [23:0] CFG_RESET = 24'h000000;

  // Query register fields
  localparam int QUERY_IDX_LSB = 16;
  localparam int QUERY_IDX_W = 3;

  // Reset and status values
  localparam logic [31:0] SYSFAULT_HEALTHY = 32'h00000003;
  localparam logic [31:0] SYSFAULT_BUS_BITS = 32'h00000003;
  localparam logic [15:0] io_status_ok_code = 16'h0000;
  localparam logic [15:0] io_status_bus_fault_code = 16'h0001;
  localparam logic [15:0] module_healthy_value = 16'h0000;
  localparam logic [15:0] module_bus_fault_value = 16'h0002;
  localparam logic [15:0] query_ok_code = 16'h0000;
  localparam logic [15:0] query_bus_fault_code = 16'h0001;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Failure counting and hold time
  localparam logic [1:0] FAIL_LIMIT = 2'd2;
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned HOLD_TIME_S = 10;
  localparam longint unsigned HOLD_CYCLES_DEF = HOLD_TIME_S * CLK_HZ;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_OFF = 3'b010,
    ST_RESTART = 3'b100
  } bus_state_e;

  typedef logic [N_MOD-1:0] mod_mask_t;
  typedef logic [N_MOD-1:0][DATA_W-1:0] mod_data_t;

  typedef struct packed {
    mod_mask_t exch_ok;
    mod_mask_t disturbed;
    mod_data_t in_data;
  } chain_in_s;

  typedef struct packed {
    logic bus_enable;
    logic reconfig;
    mod_mask_t retry;
    mod_data_t out_data;
  } chain_out_s;

endpackage : expbus_sup_pkg

// >>> design/expbus_sup.sv
/*
  Expansion bus error supervisor: counts exchange failures per module, raises
  the bus error indications, applies active (bus off) or passive (hold and
  retry) handling, and restarts the bus on request. Registers over AXI4-Lite.
  Assumes chain_in is valid on each task_tick and the chain honours chain_out.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps

module expbus_sup #(
  parameter logic [expbus_sup_pkg::HOLD_W-1:0] HOLD_CYCLES =
    expbus_sup_pkg::HOLD_W'(expbus_sup_pkg::HOLD_CYCLES_DEF)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Expansion chain
  input wire logic task_tick,
  input wire expbus_sup_pkg::chain_in_s chain_in,
  output expbus_sup_pkg::chain_out_s chain_out,
  // Controller events and indications
  input wire logic app_download,
  output logic io_fault_led
);
  import expbus_sup_pkg::*;

  typedef struct packed {
    bus_state_e st;
    logic aw_pend;
    logic [7:0] aw_addr;
    logic w_pend;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic passive;
    logic [QUERY_IDX_W-1:0] query_idx;
    logic [23:0] cfg;
    mod_mask_t mod_err;
    mod_mask_t hold_exp;
    logic [N_MOD-1:0][1:0] fail_cnt;
    logic [N_MOD-1:0][HOLD_W-1:0] hold_cnt;
    mod_data_t out_img;
    mod_data_t in_img;
    mod_data_t drive;
  } state_s;

  state_s r_reg;
  state_s r_next;

  // Per-module next values, built in the generate loop
  mod_mask_t err_n;
  mod_mask_t hexp_n;
  logic [N_MOD-1:0][1:0] fail_n;
  logic [N_MOD-1:0][HOLD_W-1:0] hcnt_n;
  mod_data_t out_img_n;
  mod_data_t in_img_n;
  mod_data_t drive_n;

  logic wr_fire;
  logic [7:0] wr_addr;
  logic bus_err;
  logic bus_off;
  logic fault_bits_clear;
  logic restart_req;
  logic restart_ok;
  logic reset_cmd;
  logic clr_all;
  logic [31:0] sysfault_word;
  logic [15:0] io_status_word_a;
  logic [15:0] io_status_word_b;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a < OFS_END) && !(a > OFS_BUSSTAT && a < OFS_MODSTATE);
  endfunction : mapped

  assign wr_fire = r_reg.aw_pend && r_reg.w_pend && !r_reg.bvalid;
  assign wr_addr = r_reg.aw_addr;

  assign bus_err = |r_reg.mod_err;
  assign bus_off = (r_reg.st == ST_OFF);
  assign sysfault_word = bus_err ? (SYSFAULT_HEALTHY & ~SYSFAULT_BUS_BITS) : SYSFAULT_HEALTHY;
  assign io_status_word_a = bus_err ? io_status_bus_fault_code : io_status_ok_code;
  assign io_status_word_b = bus_err ? io_status_bus_fault_code : io_status_ok_code;
  assign fault_bits_clear = ((sysfault_word & SYSFAULT_BUS_BITS) == 32'h00000000);

  // A write of one to the request bit is the rising edge; the bit itself never stores
  assign restart_req = wr_fire && (wr_addr == OFS_CTRL) && r_reg.w_strb[0]
                       && r_reg.w_data[CTRL_RESTART_BIT];
  assign restart_ok = restart_req && !r_reg.passive && fault_bits_clear && bus_err;
  assign reset_cmd = wr_fire && (wr_addr == OFS_CTRL) && r_reg.w_strb[0] && r_reg.w_data[CTRL_RESETCMD_BIT];
  assign clr_all = reset_cmd || app_download || (r_reg.st == ST_RESTART);

  genvar gi;
  generate
    for (gi = 0; gi < N_MOD; gi++) begin : g_mod
      logic present;
      logic required;
      logic newer;
      logic failing;
      logic hard_fail;
      logic disturbed;
      logic ok;

      assign present = r_reg.cfg[CFG_PRESENT_LSB + gi];
      assign required = present && !r_reg.cfg[CFG_OPTIONAL_LSB + gi];
      assign newer = r_reg.cfg[CFG_NEWER_LSB + gi];
      assign ok = chain_in.exch_ok[gi];
      assign failing = (r_reg.fail_cnt[gi] == FAIL_LIMIT);
      assign hard_fail = (fail_n[gi] == FAIL_LIMIT) && required;
      assign disturbed = r_reg.passive && chain_in.disturbed[gi] && required;

      always_comb begin
        if (clr_all) begin
          fail_n[gi] = 2'd0;
        end else if (task_tick && present && !bus_off) begin
          if (ok) begin
            fail_n[gi] = 2'd0;
          end else if (r_reg.fail_cnt[gi] != FAIL_LIMIT) begin
            fail_n[gi] = r_reg.fail_cnt[gi] + 2'd1;
          end else begin
            fail_n[gi] = r_reg.fail_cnt[gi];
          end
        end else begin
          fail_n[gi] = r_reg.fail_cnt[gi];
        end

        // Active errors latch until restart, reset command or download; passive ones follow each exchange
        if (clr_all) begin
          err_n[gi] = 1'b0;
        end else if (r_reg.passive) begin
          err_n[gi] = task_tick ? (hard_fail || disturbed) : r_reg.mod_err[gi];
        end else begin
          err_n[gi] = r_reg.mod_err[gi] || hard_fail;
        end

        // Hold timer only runs for a newer-family module failing in passive mode
        if (clr_all || !(r_reg.passive && failing && newer)) begin
          hcnt_n[gi] = '0;
          hexp_n[gi] = 1'b0;
        end else if (r_reg.hold_cnt[gi] >= HOLD_CYCLES - HOLD_W'(1)) begin
          hcnt_n[gi] = r_reg.hold_cnt[gi];
          hexp_n[gi] = 1'b1;
        end else begin
          hcnt_n[gi] = r_reg.hold_cnt[gi] + HOLD_W'(1);
          hexp_n[gi] = 1'b0;
        end

        if (bus_off || clr_all) begin
          out_img_n[gi] = '0;
        end else if (wr_fire && wr_addr == OFS_OUTIMG + 8'(gi * 4) && r_reg.w_strb[0]) begin
          out_img_n[gi] = r_reg.w_data[DATA_W-1:0];
        end else begin
          out_img_n[gi] = r_reg.out_img[gi];
        end

        if (bus_off || clr_all) begin
          in_img_n[gi] = '0;
        end else if (task_tick && present && ok) begin
          in_img_n[gi] = chain_in.in_data[gi];
        end else begin
          in_img_n[gi] = r_reg.in_img[gi];
        end

        if (bus_off || clr_all) begin
          drive_n[gi] = '0;
        end else if (r_reg.passive && failing) begin
          if (newer && r_reg.hold_exp[gi]) begin
            drive_n[gi] = '0;
          end else begin
            drive_n[gi] = r_reg.drive[gi];
          end
        end else begin
          // Disturbed modules still answer, so they keep getting live data
          drive_n[gi] = r_reg.out_img[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    logic [7:0] ra;
    logic [2:0] mi;
    r_next = r_reg;
    ra = araddr;
    mi = ra[4:2];

    // Per-module state gathered from the generate loop
    r_next.fail_cnt = fail_n;
    r_next.mod_err = err_n;
    r_next.hold_cnt = hcnt_n;
    r_next.hold_exp = hexp_n;
    r_next.out_img = out_img_n;
    r_next.in_img = in_img_n;
    r_next.drive = drive_n;

    // Bus state; passive handling never goes bus off, so the controller keeps running
    unique case (r_reg.st)
      ST_RUN: begin
        if (!clr_all && !r_reg.passive && bus_err) begin
          r_next.st = ST_OFF;
        end else begin
          r_next.st = ST_RUN;
        end
      end
      ST_OFF: begin
        if (reset_cmd || app_download) begin
          r_next.st = ST_RUN;
        end else if (restart_ok) begin
          r_next.st = ST_RESTART;
        end else begin
          r_next.st = ST_OFF;
        end
      end
      ST_RESTART: begin
        r_next.st = ST_RUN;
      end
      default: begin
        r_next.st = ST_RUN;
      end
    endcase

    // Write channel acceptance, either order
    if (awvalid && awready) begin
      r_next.aw_pend = 1'b1;
      r_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      r_next.w_pend = 1'b1;
      r_next.w_data = wdata;
      r_next.w_strb = wstrb;
    end
    if (wr_fire) begin
      r_next.aw_pend = 1'b0;
      r_next.w_pend = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_addr == OFS_CTRL && r_reg.w_strb[0]) begin
        r_next.passive = r_reg.w_data[CTRL_PASSIVE_BIT];
      end
      if (wr_addr == OFS_CFG) begin
        r_next.cfg = 24'(merge({8'h00, r_reg.cfg}, r_reg.w_data, r_reg.w_strb));
      end
      if (wr_addr == OFS_QUERY && r_reg.w_strb[2]) begin
        r_next.query_idx = r_reg.w_data[QUERY_IDX_LSB +: QUERY_IDX_W];
      end
    end else if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end

    // Read channel: one cycle to data, held until rready
    if (arvalid && arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      r_next.rdata = 32'h00000000;
      if (mapped(ra)) begin
        case (ra & OFS_BANK_MASK)
          OFS_MODSTATE: begin
            r_next.rdata = {16'h0000, r_reg.mod_err[mi] ? module_bus_fault_value : module_healthy_value};
          end
          OFS_OUTIMG: begin
            r_next.rdata = {24'h000000, r_reg.out_img[mi]};
          end
          OFS_INIMG: begin
            r_next.rdata = {24'h000000, r_reg.in_img[mi]};
          end
          default: begin
            case (ra)
              OFS_CTRL: r_next.rdata = {31'h00000000, r_reg.passive};
              OFS_CFG: r_next.rdata = {8'h00, r_reg.cfg};
              OFS_SYSFAULT: r_next.rdata = sysfault_word;
              OFS_IOSTAT: r_next.rdata = {io_status_word_b, io_status_word_a};
              OFS_QUERY: begin
                r_next.rdata = {13'h0000, r_reg.query_idx,
                                r_reg.mod_err[r_reg.query_idx] ? query_bus_fault_code : query_ok_code};
              end
              OFS_BUSSTAT: begin
                r_next.rdata = {8'h00, r_reg.hold_exp, r_reg.mod_err, 5'h00, r_reg.st};
              end
              default: r_next.rdata = 32'h00000000;
            endcase
          end
        endcase
      end
    end else if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '{
        st: ST_RUN,
        passive: 1'b0,
        cfg: CFG_RESET,
        bresp: RESP_OKAY,
        rresp: RESP_OKAY,
        default: '0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // Handshake outputs
  assign awready = !r_reg.aw_pend && !r_reg.bvalid;
  assign wready = !r_reg.w_pend && !r_reg.bvalid;
  assign arready = !r_reg.rvalid;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign rvalid = r_reg.rvalid;
  assign rdata = r_reg.rdata;
  assign rresp = r_reg.rresp;

  // Chain side
  assign chain_out.bus_enable = (r_reg.st == ST_RUN);
  assign chain_out.reconfig = (r_reg.st == ST_RESTART);
  // No retries while the bus is stopped, even if passive was chosen during bus off
  assign chain_out.retry = (r_reg.passive && r_reg.st == ST_RUN) ? r_reg.mod_err : '0;
  assign chain_out.out_data = r_reg.drive;

  assign io_fault_led = bus_err;

endmodule : expbus_sup

// >>> verif/expbus_chain_model.sv
/*
  Behavioural chain of eight expansion modules facing the supervisor.
  Assumes the bench picks which modules answer and which are disturbed.
*/
`timescale 1ns/10ps
module expbus_chain_model (
  // Clock
  input wire logic aclk,
  // Bench control
  input wire expbus_sup_pkg::mod_mask_t alive,
  input wire expbus_sup_pkg::mod_mask_t disturb,
  // Supervisor side
  input wire expbus_sup_pkg::chain_out_s chain_out,
  output expbus_sup_pkg::chain_in_s chain_in
);
  import expbus_sup_pkg::*;
  logic [7:0] junk_reg;
  initial junk_reg = 8'h00;
  always @(posedge aclk) junk_reg <= junk_reg + 8'h3b;
  always_comb begin
    chain_in.exch_ok = alive & {N_MOD{chain_out.bus_enable}};
    chain_in.disturbed = disturb;
    for (int i = 0; i < N_MOD; i++) begin
      // Silent module: moving junk, never a stale value
      chain_in.in_data[i] = alive[i] ? chain_out.out_data[i] ^ 8'h5a : junk_reg;
    end
  end
endmodule : expbus_chain_model

// >>> verif/expbus_sup_sva.sv
/*
  Checker on the supervisor's chain side and fault indicator.
  Bound to every expbus_sup instance; single clock aclk.
*/
`timescale 1ns/10ps
module expbus_sup_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic task_tick,
  input wire expbus_sup_pkg::chain_out_s chain_out,
  input wire logic io_fault_led
);
  import expbus_sup_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_idle;
    $rose(aresetn) |-> chain_out.bus_enable && !io_fault_led && !chain_out.reconfig;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  property p_reconf_pulse;
    chain_out.reconfig |=> !chain_out.reconfig;
  endproperty
  a_reconf_pulse: assert property (p_reconf_pulse) else $error("restart pulse too long");
  property p_reconf_cause;
    $rose(chain_out.reconfig) |-> $past(io_fault_led);
  endproperty
  a_reconf_cause: assert property (p_reconf_cause) else $error("restart with no module error");
  property p_reconf_run;
    chain_out.reconfig |-> !chain_out.bus_enable ##1 chain_out.bus_enable;
  endproperty
  a_reconf_run: assert property (p_reconf_run) else $error("bus not back after restart");
  property p_led_tick;
    $rose(io_fault_led) |-> $past(task_tick);
  endproperty
  a_led_tick: assert property (p_led_tick) else $error("fault raised off a task tick");
  property p_off_cause;
    $fell(chain_out.bus_enable) |-> $past(io_fault_led) && !chain_out.reconfig;
  endproperty
  a_off_cause: assert property (p_off_cause) else $error("bus off without error");
  property p_off_zero;
    !chain_out.bus_enable && !$past(chain_out.bus_enable) |-> chain_out.out_data == '0;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("outputs live while bus off");
  property p_retry_run;
    chain_out.retry != '0 |-> chain_out.bus_enable;
  endproperty
  a_retry_run: assert property (p_retry_run) else $error("retry while bus stopped");
endmodule : expbus_sup_chk

bind expbus_sup expbus_sup_chk chk (.aclk(aclk), .aresetn(aresetn), .task_tick(task_tick),
  .chain_out(chain_out), .io_fault_led(io_fault_led));

// >>> verif/tb_top.sv
/*
  Self-checking bench: AXI4-Lite master, tick source, chain model.
  Assumes the supervisor's register bus timing; hold shortened to 200.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import expbus_sup_pkg::*;
  localparam int HOLD = 200;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, task_tick, app_download, io_fault_led;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r;
  chain_in_s chain_in;
  chain_out_s chain_out;
  mod_mask_t alive, disturb;
  logic [7:0] oimg [N_MOD];
  int seed, n_mismatch, checks_done, n_reconf, cyc, nr;
  expbus_sup #(.HOLD_CYCLES(HOLD_W'(HOLD))) dut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .task_tick(task_tick), .chain_in(chain_in), .chain_out(chain_out),
    .app_download(app_download), .io_fault_led(io_fault_led));
  expbus_chain_model chain (.aclk(aclk), .alive(alive), .disturb(disturb),
    .chain_out(chain_out), .chain_in(chain_in));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (chain_out.reconfig) n_reconf++;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  function automatic logic [31:0] sysf_exp(input logic f);
    return f ? SYSFAULT_HEALTHY & ~SYSFAULT_BUS_BITS : SYSFAULT_HEALTHY;
  endfunction : sysf_exp
  function automatic logic [31:0] iostat_exp(input logic f);
    return f ? {2{io_status_bus_fault_code}} : {2{io_status_ok_code}};
  endfunction : iostat_exp
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    rd_r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rd_v = rdata;
    rd_r = rresp;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_v, e)
  endtask : rc
  task automatic tk(input mod_mask_t a, input int n);
    repeat (n) begin
      @(posedge aclk);
      alive <= a;
      task_tick <= 1'b1;
      @(posedge aclk);
      task_tick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask : tk
  // Indicator, fault word, status words and every module state word
  task automatic health(input mod_mask_t m);
    `CHK(io_fault_led, 1'(m != '0))
    rc(OFS_SYSFAULT, sysf_exp(m != '0));
    rc(OFS_IOSTAT, iostat_exp(m != '0));
    for (int i = 0; i < N_MOD; i++)
      rc(OFS_MODSTATE + 8'(4 * i), {16'h0, m[i] ? module_bus_fault_value : module_healthy_value});
  endtask : health
  initial begin
    {seed, n_mismatch, checks_done, n_reconf, cyc} = {32'd28, 128'd0};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, task_tick, app_download} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    alive = 8'h7f;
    disturb = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_CTRL, 32'h0);
    health('0);
    // Module 7 optional and silent; 0..3 newer family
    wr(OFS_CFG, 32'h000f_80ff);
    for (int i = 0; i < N_MOD; i++) begin
      oimg[i] = 8'($random(seed));
      wr(OFS_OUTIMG + 8'(4 * i), {24'h0, oimg[i]});
    end
    tk(8'h7f, 3);
    for (int i = 0; i < 7; i++) rc(OFS_INIMG + 8'(4 * i), {24'h0, oimg[i] ^ 8'h5a});
    health('0);
    wr(OFS_CTRL, 32'h1);
    rc(OFS_CTRL, 32'h1);
    disturb <= 8'h08;
    tk(8'h5d, 2);
    `CHK(chain_out.out_data[1], oimg[1])
    `CHK(chain_out.out_data[3], oimg[3])
    `CHK({chain_out.bus_enable, chain_out.retry[1], chain_out.retry[5]}, 3'h7)
    wr(OFS_OUTIMG + 8'h04, {24'h0, ~oimg[1]});
    rc(OFS_OUTIMG + 8'h04, {24'h0, ~oimg[1]});
    rc(OFS_INIMG + 8'h04, {24'h0, oimg[1] ^ 8'h5a});
    health(8'h2a);
    repeat (HOLD) @(posedge aclk);
    `CHK(chain_out.out_data[1], 8'h00)
    `CHK(chain_out.out_data[5], oimg[5])
    disturb <= '0;
    tk(8'h7f, 2);
    `CHK(chain_out.out_data[1], ~oimg[1])
    rc(OFS_INIMG + 8'h04, {24'h0, ~oimg[1] ^ 8'h5a});
    health('0);
    wr(OFS_CTRL, 32'h0);
    // Lone failures on module 2, each followed by a good exchange
    for (int k = 0; k < 4; k++) tk(k[0] ? 8'h7f : 8'h7b, 1);
    health('0);
    tk(8'h7b, 2);
    health(8'h04);
    `CHK(chain_out.out_data, mod_data_t'(0))
    rc(OFS_INIMG, 32'h0);
    for (int i = 2; i < 4; i++) begin
      wr(OFS_QUERY, 32'(i) << 16);
      rc(OFS_QUERY, {16'(i), i == 2 ? query_bus_fault_code : query_ok_code});
    end
    tk(8'h7f, 2);
    rd(OFS_BUSSTAT);
    `CHK(rd_v[2:0], 3'b010)
    nr = n_reconf;
    wr(OFS_CTRL, 32'h2);
    repeat (3) @(posedge aclk);
    `CHK(n_reconf, nr + 1)
    rc(OFS_CTRL, 32'h0);
    health('0);
    wr(OFS_CTRL, 32'h2);
    // Bus off, then passive chosen: the restart must be refused
    tk(8'h7b, 2);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h3);
    repeat (3) @(posedge aclk);
    `CHK(n_reconf, nr + 1)
    rd(OFS_BUSSTAT);
    `CHK(rd_v[2:0], 3'b010)
    tk(8'h7f, 2);
    wr(OFS_CTRL, 32'h4);
    for (int k = 0; k < 2; k++) begin
      tk(8'h7b, 2);
      `CHK(io_fault_led, 1'b1)
      alive <= 8'h7f;
      if (k == 0) wr(OFS_CTRL, 32'h4);
      else begin
        app_download <= 1'b1;
        @(posedge aclk);
        app_download <= 1'b0;
      end
      repeat (3) @(posedge aclk);
      health('0);
    end
    // Byte lane 1 only: optional mask cleared, other fields kept
    wstrb <= 4'h2;
    wr(OFS_CFG, 32'h0000_0000);
    wstrb <= 4'hf;
    rc(OFS_CFG, 32'h000f_00ff);
    wr(8'h18, 32'hffff_ffff);
    `CHK(rd_r, RESP_SLVERR)
    rd(8'h18);
    `CHK({rd_r, rd_v}, {RESP_SLVERR, 32'h0})
    summarize();
  end
endmodule : tb_top
